// ===== design/frp_pkg.sv
// Package for the flash rewrite protect control block.
// Assumes a 32-bit AHB-Lite slave with word registers.
package frp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_STATUS_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_ROM_PROTECT = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_CMD_DATA = 8'h10;
    localparam logic [7:0] OFS_PROG_CTRL = 8'h14;
    localparam logic [7:0] OFS_PROG_STAT = 8'h18;
    localparam logic [7:0] OFS_ID_WORD0 = 8'h1C;
    localparam logic [7:0] OFS_ID_WORD1 = 8'h20;
    localparam logic [7:0] OFS_CFG = 8'h24;
    // Field positions of flash_ctrl_status_a
    localparam int BIT_READY = 0;
    localparam int BIT_REWRITE_EN = 1;
    localparam int BIT_LOCK_DIS = 2;
    localparam int BIT_FLASH_STOP = 3;
    localparam int BIT_AREA_SEL = 5;
    localparam int BIT_PROG_ERR = 6;
    localparam int BIT_ERASE_ERR = 7;
    // Field positions of flash_ctrl_b
    localparam int BIT_EW_SEL = 1;
    localparam int BIT_LOCK_RESULT = 6;
    // Protect level field and its open code
    localparam int BIT_PROT_LVL = 6;
    localparam logic [1:0] PROT_OPEN = 2'b11;
    localparam logic [31:0] VEC_ERASED = 32'hFFFF_FFFF;
    // Identification code byte addresses, spaced four apart except eight from the second to the third
    localparam logic [19:0] ID_ADDR_FIRST = 20'hF_FFDF;
    localparam logic [19:0] ID_ADDR_STEP = 20'h0_0004;
    localparam int ID_BYTES = 7;
    // Command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
    localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
    localparam logic [7:0] CMD_READ_LOCK = 8'h71;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    // Reset values
    localparam logic [7:0] RST_CTRL_A = 8'h01;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    // Operation length: 10 us at 100 MHz
    localparam int OP_TIME_NS = 10000;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [15:0] OP_CYCLES = 16'(OP_TIME_NS / CLK_PERIOD_NS);
    localparam int NUM_BLOCKS = 16;
    // Command engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SECOND = 4'b0010,
        ST_BUSY = 4'b0100,
        ST_DONE = 4'b1000
    } frp_state_e;
endpackage

// ===== design/frp_unlock_seq.sv
// Zero-then-one arming sequence for one protected control bit.
// Assumes write strobes are one-cycle pulses from the bus slave.
`timescale 1ns/1ps
`default_nettype none
module frp_unlock_seq (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr,
    input wire logic wdata,
    input wire logic allow,
    input wire logic force_clr,
    output logic bit_q
);
    logic armed_r;
    logic bit_r;
    // A 1 counts only right after a written 0, to shield against stray writes
    always_ff @(posedge clk) begin
        if (rst || force_clr) begin
            armed_r <= 1'b0;
            bit_r <= 1'b0;
        end else if (ce && wr) begin
            armed_r <= ~wdata;
            bit_r <= wdata ? (armed_r & allow) | bit_r : 1'b0;
        end
    end
    assign bit_q = bit_r;
endmodule
`default_nettype wire

// ===== design/frp_ctrl.sv
// Flash rewrite protect and erase-write control, AHB-Lite register slave.
// Assumes a single master, word transfers, and an external flash array
// model that reports operation failure through a port; lock bits are loaded through the config register.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Parallel mode blocks flash read, but not rewrite commands, unless protect level is 11b.
// - Serial/CAN mode rejects programmer commands on identification code mismatch.
// - All-ones reset vector skips the identification check, accepts every command.
// - Stored code is seven bytes at fixed addresses spaced four apart, eight between second and third.
// - CPU rewrite only programs or erases the user area, never boot area.
// - Variant one refuses program or erase on the control program block.
// - Variant one refuses erase-all if control block unlocked or lock disabled.
// - After operation: read-status in variant zero, read-array in variant one.
// - Variant one holds the CPU until completion or erase-suspend.
// - Rewrite-enable sets only by writing 0 then 1; then commands accepted.
// - Variant select 0 is zero, 1 is one; needs 0-then-1 after enable.
// - Variant one does not support reading the command status register.
// - Ready flag is 0 while an operation executes, otherwise 1.
// - In boot mode area select 0 reads boot area, 1 accesses user area.
// - Lock disable suspends locks; erase under it unlocks affected blocks.
// - Flash stop resets control, lowers power and denies all accesses.
// - Flash powers down in stop or wait mode and back up on exit.
// - Read-only program and erase error flags show a failed operation.
// - Lock-status read sets result 0 when locked, 1 when unlocked.
// - Rewrite mode forces extra block enable and area expand to 1.
// - Program starts with 40h then data to the same even address.
// - Non-maskable or watchdog request in variant zero resets both registers.
module frp_ctrl
    import frp_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic PARALLEL_MODE,
    input wire logic SERIAL_MODE,
    input wire logic BOOT_MODE,
    input wire logic LOW_POWER_MODE,
    input wire logic NMI_REQ,
    input wire logic WDT_REQ,
    input wire logic ERASE_SUSPEND,
    input wire logic OP_FAIL,
    input wire logic [31:0] RESET_VECTOR,
    input wire logic [55:0] STORED_ID,
    input wire logic [3:0] CTRL_PROG_BLOCK,
    input wire logic [7:0] PM1_SW,
    output logic [7:0] PM1_EFFECTIVE,
    output logic FLASH_READ_EN,
    output logic FLASH_POWER_EN,
    output logic CPU_HOLD,
    output logic READ_STATUS_MODE,
    output logic PROG_CMD_ACCEPT,
    output logic [19:0] ID_FETCH_ADDR
);
    import frp_pkg::*;

    // Bus address phase capture
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic hready_r;
    logic [7:0] rom_protect_r;
    logic [7:0] lock_bits_r;
    logic [15:0] locks_r;
    logic lock_dis_r;
    logic area_sel_r;
    logic flash_stop_r;
    logic prog_err_r;
    logic erase_err_r;
    logic lock_result_r;
    logic read_status_r;
    logic [7:0] cmd1_r;
    logic [3:0] cmd_blk_r;
    logic [15:0] cnt_r;
    logic [55:0] rx_id_r;
    logic [2:0] id_idx_r;
    logic hold_r;
    logic [7:0] pm1_r;
    logic flash_rd_r;
    logic power_r;
    logic accept_r;
    logic [19:0] id_addr_r;
    frp_state_e state_r;
    frp_state_e state_nxt;
    logic rewrite_en;
    logic ew_sel;

    // Decode of write and read accesses
    wire addr_ph = HSEL && HREADY && HTRANS[1];
    wire wr_ce = CE && wr_pend_r;
    wire wr_a = wr_ce && (wr_addr_r == OFS_CTRL_STATUS_A);
    wire wr_b = wr_ce && (wr_addr_r == OFS_CTRL_B);
    wire wr_cmd = wr_ce && (wr_addr_r == OFS_CMD);
    wire wr_data = wr_ce && (wr_addr_r == OFS_CMD_DATA);
    wire wr_pctl = wr_ce && (wr_addr_r == OFS_PROG_CTRL);
    wire wr_id0 = wr_ce && (wr_addr_r == OFS_ID_WORD0);
    wire wr_id1 = wr_ce && (wr_addr_r == OFS_ID_WORD1);
    wire wr_cfg = wr_ce && (wr_addr_r == OFS_CFG);
    wire busy = (state_r == ST_BUSY);
    wire ew1 = ew_sel;
    // Emergency request resets both control registers in variant zero
    wire emerg = (NMI_REQ || WDT_REQ) && rewrite_en && !ew1;
    wire nmi_ew1 = NMI_REQ && rewrite_en && ew1;
    wire ctl_clr = emerg || nmi_ew1 || flash_stop_r;

    // Arming sequences for the two protected bits
    frp_unlock_seq u_rewrite (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .wr(wr_a),
        .wdata(HWDATA[BIT_REWRITE_EN]),
        .allow(1'b1),
        .force_clr(emerg || nmi_ew1),
        .bit_q(rewrite_en)
    );
    frp_unlock_seq u_variant (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .wr(wr_b),
        .wdata(HWDATA[BIT_EW_SEL]),
        .allow(rewrite_en && !BOOT_MODE),
        .force_clr(emerg || nmi_ew1 || !rewrite_en),
        .bit_q(ew_sel)
    );

    // Guards on incoming commands
    wire cmd_ok = rewrite_en && !flash_stop_r && !busy;
    wire user_area = !BOOT_MODE || area_sel_r;
    wire [3:0] tgt_blk = HWDATA[19:16];
    wire blk_locked = !lock_dis_r && !locks_r[tgt_blk];
    wire self_blk = ew1 && (tgt_blk == CTRL_PROG_BLOCK);
    wire eall_bad = ew1 && (locks_r[CTRL_PROG_BLOCK] || lock_dis_r);
    wire is_prog = cmd1_r == CMD_PROGRAM;
    wire is_berase = cmd1_r == CMD_BLOCK_ERASE;
    wire is_eall = cmd1_r == CMD_ERASE_ALL;
    wire is_lprog = cmd1_r == CMD_LOCK_PROG;
    wire is_rlock = cmd1_r == CMD_READ_LOCK;
    wire confirm = HWDATA[7:0] == CMD_CONFIRM;
    // Second cycle: program carries data, others need the confirm code
    wire second_ok = is_prog ? (user_area && !self_blk && !blk_locked)
        : (is_berase ? (confirm && user_area && !self_blk && !blk_locked)
        : (is_eall ? (confirm && user_area && !eall_bad)
        : ((is_lprog || is_rlock) && confirm)));
    wire two_cycle = (HWDATA[7:0] == CMD_PROGRAM) ||
        (HWDATA[7:0] == CMD_BLOCK_ERASE) ||
        (HWDATA[7:0] == CMD_ERASE_ALL) ||
        (HWDATA[7:0] == CMD_LOCK_PROG) ||
        (HWDATA[7:0] == CMD_READ_LOCK);
    wire op_end = busy && ((cnt_r == OP_CYCLES) || (ERASE_SUSPEND && ew1));
    wire id_match = (rx_id_r == STORED_ID);
    wire vec_blank = (RESET_VECTOR == VEC_ERASED);
    wire prot_open = rom_protect_r[BIT_PROT_LVL+:2] == PROT_OPEN;

    // Command engine next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (wr_cmd && cmd_ok && two_cycle) state_nxt = ST_SECOND;
            ST_SECOND: if (wr_data || wr_cmd)
                state_nxt = (wr_data && second_ok) ? ST_BUSY : ST_IDLE;
            ST_BUSY: if (op_end) state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
        if (ctl_clr) state_nxt = ST_IDLE;
    end

    // Bus address phase and zero-wait answer
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hready_r <= 1'b1;
        end else if (CE) begin
            wr_pend_r <= addr_ph && HWRITE;
            wr_addr_r <= HADDR[7:0];
            hready_r <= 1'b1;
        end
    end

    // Read mux; status register read unavailable in variant one
    wire [7:0] reg_a = {erase_err_r, prog_err_r, area_sel_r, 1'b0,
        flash_stop_r, lock_dis_r, rewrite_en, !busy};
    wire [7:0] reg_b = {1'b0, lock_result_r, 4'h0, ew_sel, 1'b0};
    wire [7:0] srd = ew1 ? 8'h00
        : {!busy, 1'b0, erase_err_r, prog_err_r, 4'h0};
    wire [7:0] ra = HADDR[7:0];
    wire [31:0] rd_mux =
        (ra == OFS_CTRL_STATUS_A) ? {24'h00_0000, reg_a} :
        (ra == OFS_CTRL_B) ? {24'h00_0000, reg_b} :
        (ra == OFS_ROM_PROTECT) ? {24'h00_0000, rom_protect_r} :
        (ra == OFS_CMD) ? {24'h00_0000, srd} :
        (ra == OFS_PROG_STAT) ? {28'h000_0000, accept_r, id_idx_r} :
        (ra == OFS_CFG) ? {16'h0000, locks_r} : 32'h0000_0000;
    always_ff @(posedge CLK_SYS) begin
        if (RST) rdata_r <= 32'h0000_0000;
        else if (CE && addr_ph && !HWRITE) rdata_r <= rd_mux;
    end

    // Control bits, flags and command state
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_r <= ST_IDLE;
            lock_dis_r <= 1'b0;
            area_sel_r <= 1'b0;
            flash_stop_r <= 1'b0;
            prog_err_r <= 1'b0;
            erase_err_r <= 1'b0;
            lock_result_r <= 1'b0;
            read_status_r <= 1'b0;
            cmd1_r <= 8'h00;
            cmd_blk_r <= 4'h0;
            cnt_r <= 16'h0000;
        end else if (CE) begin
            state_r <= state_nxt;
            cnt_r <= busy ? cnt_r + 16'h0001 : 16'h0000;
            if (wr_a) begin
                // Stop bit may be written at any time; others clear on emerg or nmi_ew1
                flash_stop_r <= HWDATA[BIT_FLASH_STOP];
                lock_dis_r <= HWDATA[BIT_LOCK_DIS] && rewrite_en;
                area_sel_r <= HWDATA[BIT_AREA_SEL];
            end else if (emerg || nmi_ew1) begin
                lock_dis_r <= 1'b0;
                area_sel_r <= 1'b0;
            end
            if (wr_cmd && cmd_ok) begin
                cmd1_r <= HWDATA[7:0];
                if (HWDATA[7:0] == CMD_CLEAR_STATUS) begin
                    prog_err_r <= 1'b0;
                    erase_err_r <= 1'b0;
                end
                if (HWDATA[7:0] == CMD_READ_ARRAY) read_status_r <= 1'b0;
                if (HWDATA[7:0] == CMD_READ_STATUS && !ew1)
                    read_status_r <= 1'b1;
            end
            if (wr_data && state_r == ST_SECOND) cmd_blk_r <= tgt_blk;
            // Variant zero enters read-status as an operation starts
            if (state_nxt == ST_BUSY && state_r == ST_SECOND)
                read_status_r <= !ew1;
            if (op_end) begin
                // Failure is sticky until cleared; set wins over clear
                if (is_prog && OP_FAIL) prog_err_r <= 1'b1;
                if ((is_berase || is_eall) && OP_FAIL) erase_err_r <= 1'b1;
                if (is_rlock) lock_result_r <= locks_r[cmd_blk_r];
                read_status_r <= !ew1;
            end
            if (ctl_clr && !wr_a) read_status_r <= 1'b0;
        end
    end

    // Lock bits: lock program locks, erase under lock disable unlocks
    always_ff @(posedge CLK_SYS) begin
        if (RST) locks_r <= 16'h0000;
        else if (CE && wr_cfg) locks_r <= HWDATA[15:0];
        else if (CE && op_end && !OP_FAIL) begin
            if (is_lprog) locks_r[cmd_blk_r] <= 1'b0;
            if (is_berase && lock_dis_r) locks_r[cmd_blk_r] <= 1'b1;
            if (is_eall && lock_dis_r) locks_r <= 16'hFFFF;
        end
    end

    // Protect word and programmer identification path
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rom_protect_r <= 8'hFF;
            rx_id_r <= 56'h00_0000_0000_0000;
            id_idx_r <= 3'h0;
            id_addr_r <= ID_ADDR_FIRST;
        end else if (CE) begin
            if (wr_pctl) rom_protect_r <= HWDATA[7:0];
            // Erasing the protect block reopens parallel access
            if (op_end && is_berase && !OP_FAIL &&
                    cmd_blk_r == CTRL_PROG_BLOCK)
                rom_protect_r <= 8'hFF;
            if (wr_id0) rx_id_r[31:0] <= HWDATA;
            if (wr_id1) rx_id_r[55:32] <= HWDATA[23:0];
            // Walk the seven stored bytes; the third sits one slot further on
            if (SERIAL_MODE) begin
                id_idx_r <= (id_idx_r == 3'(ID_BYTES - 1)) ? 3'h0
                    : id_idx_r + 3'h1;
                id_addr_r <= (id_idx_r == 3'(ID_BYTES - 1)) ? ID_ADDR_FIRST
                    : id_addr_r + ((id_idx_r == 3'h1) ? ID_ADDR_STEP << 1
                    : ID_ADDR_STEP);
            end
        end
    end

    // Registered outputs toward the CPU and flash array
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hold_r <= 1'b0;
            pm1_r <= 8'h00;
            flash_rd_r <= 1'b1;
            power_r <= 1'b1;
            accept_r <= 1'b0;
        end else if (CE) begin
            hold_r <= ew1 && (state_nxt == ST_BUSY);
            pm1_r <= rewrite_en ? (PM1_SW | 8'h09) : PM1_SW;
            flash_rd_r <= !flash_stop_r && !(PARALLEL_MODE && !prot_open)
                && !(state_nxt == ST_BUSY && !ew1);
            power_r <= !flash_stop_r && !LOW_POWER_MODE;
            accept_r <= SERIAL_MODE && (vec_blank || id_match);
        end
    end

    assign HRDATA = rdata_r;
    assign HREADYOUT = hready_r;
    assign HRESP = 1'b0;
    assign PM1_EFFECTIVE = pm1_r;
    assign FLASH_READ_EN = flash_rd_r;
    assign FLASH_POWER_EN = power_r;
    assign CPU_HOLD = hold_r;
    assign READ_STATUS_MODE = read_status_r;
    assign PROG_CMD_ACCEPT = accept_r;
    assign ID_FETCH_ADDR = id_addr_r;
endmodule
`default_nettype wire

// ===== bench/frp_ctrl_monitor.sv
// Concurrent checks on the flash rewrite protect control top ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module frp_ctrl_monitor (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic LOW_POWER_MODE,
    input wire logic SERIAL_MODE,
    input wire logic ERASE_SUSPEND,
    input wire logic [31:0] RESET_VECTOR,
    input wire logic [7:0] PM1_SW,
    input wire logic [7:0] PM1_EFFECTIVE,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic FLASH_POWER_EN,
    input wire logic CPU_HOLD,
    input wire logic READ_STATUS_MODE,
    input wire logic PROG_CMD_ACCEPT,
    input wire logic [19:0] ID_FETCH_ADDR
);
    import frp_pkg::*;
    int hold_cnt_r;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Length of the current hold; a stuck engine shows up here
    always_ff @(posedge CLK_SYS) begin
        if (RST || !CPU_HOLD) hold_cnt_r <= 0;
        else if (CE) hold_cnt_r <= hold_cnt_r + 1;
    end
    AST_READYOUT: assert property (HREADYOUT)
        else $error("zero-wait ready dropped");
    AST_RESP_OKAY: assert property (!HRESP)
        else $error("error response seen");
    AST_POWER_DOWN: assert property (
        CE && LOW_POWER_MODE |=> !FLASH_POWER_EN)
        else $error("flash powered in low power mode");
    AST_ACCEPT_OFF: assert property (
        CE && !SERIAL_MODE |=> !PROG_CMD_ACCEPT)
        else $error("commands accepted outside serial mode");
    AST_ACCEPT_ERASED: assert property (
        (CE && SERIAL_MODE && RESET_VECTOR == VEC_ERASED) [*2]
        |=> PROG_CMD_ACCEPT)
        else $error("erased vector did not bypass code check");
    AST_PM1_KEEP: assert property (
        CE |=> PM1_EFFECTIVE[7:4] == $past(PM1_SW[7:4])
        && PM1_EFFECTIVE[2:1] == $past(PM1_SW[2:1]))
        else $error("mode register bits altered");
    AST_PM1_FORCE: assert property (
        CE && PM1_SW[0] && PM1_SW[3] |=> PM1_EFFECTIVE[0] && PM1_EFFECTIVE[3])
        else $error("set mode register bits lost");
    AST_HOLD_BOUND: assert property (
        hold_cnt_r <= int'(OP_CYCLES) + 2)
        else $error("CPU held beyond operation time");
    AST_SUSPEND: assert property (
        CE && CPU_HOLD && ERASE_SUSPEND |-> ##[1:2] !CPU_HOLD)
        else $error("suspend did not release CPU");
    AST_ID_ADDR: assert property (
        ID_FETCH_ADDR[1:0] == 2'b11 && ID_FETCH_ADDR >= ID_ADDR_FIRST
        && ID_FETCH_ADDR <= ID_ADDR_FIRST + 20'h0_001C)
        else $error("code fetch address off the list");
    AST_ARRAY_AFTER: assert property (
        $fell(CPU_HOLD) |-> ##[0:1] !READ_STATUS_MODE)
        else $error("not in read-array mode after hold");
endmodule
bind frp_ctrl frp_ctrl_monitor u_mon (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
    .LOW_POWER_MODE(LOW_POWER_MODE), .SERIAL_MODE(SERIAL_MODE),
    .ERASE_SUSPEND(ERASE_SUSPEND), .RESET_VECTOR(RESET_VECTOR),
    .PM1_SW(PM1_SW), .PM1_EFFECTIVE(PM1_EFFECTIVE),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FLASH_POWER_EN(FLASH_POWER_EN),
    .CPU_HOLD(CPU_HOLD), .READ_STATUS_MODE(READ_STATUS_MODE),
    .PROG_CMD_ACCEPT(PROG_CMD_ACCEPT), .ID_FETCH_ADDR(ID_FETCH_ADDR)
);
`default_nettype wire

// ===== bench/frp_flash_model.sv
// Flash array side: stored code, reset vector and operation outcome.
// Assumes the bench picks failure and erased vector as levels.
`timescale 1ns/1ps
`default_nettype none
module frp_flash_model #(
    parameter logic [55:0] ID_CODE = 56'h13_5724_6813_5724 // Arbitrary
) (
    input wire logic fail_req,
    input wire logic vec_erased,
    output logic op_fail,
    output logic [31:0] reset_vector,
    output logic [55:0] stored_id
);
    import frp_pkg::*;
    // Stored code, byte zero in the low bits
    assign stored_id = ID_CODE;
    // Erased vector lets every command through
    assign reset_vector = vec_erased ? VEC_ERASED : 32'h0000_F000;
    // Verify outcome as a level, held until the bench drops it
    assign op_fail = fail_req;
endmodule
`default_nettype wire

// ===== bench/frp_ctrl_bench.sv
// Self-checking bench for the flash rewrite protect control block.
// Assumes the monitor is bound in and the flash model feeds the array.
`timescale 1ns/1ps
`default_nettype none
module frp_ctrl_bench;
    import frp_pkg::*;
    localparam logic [55:0] ID_CODE = 56'h13_5724_6813_5724;
    localparam int T_STAB = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic par = 1'b0, ser = 1'b0, lpm = 1'b0, nmi = 1'b0, wdt = 1'b0;
    logic susp = 1'b0, fail_req = 1'b0, vec_erased = 1'b0;
    logic [7:0] pm1_sw = 8'hA0;
    logic [31:0] hrdata, rvec, v;
    logic [55:0] sid;
    logic [7:0] pm1_eff;
    logic hreadyout, hresp, op_fail, rd_en, pwr_en, cpu_hold, rs_mode, accept;
    logic [19:0] id_addr;
    int error_cnt = 0;
    int total_checks = 0;
    // Free-running system clock
    always #5 clk = ~clk;
    frp_ctrl u_dut (
        .CLK_SYS(clk), .RST(rst), .CE(1'b1), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .PARALLEL_MODE(par), .SERIAL_MODE(ser),
        .BOOT_MODE(1'b0), .LOW_POWER_MODE(lpm), .NMI_REQ(nmi), .WDT_REQ(wdt),
        .ERASE_SUSPEND(susp), .OP_FAIL(op_fail), .RESET_VECTOR(rvec),
        .STORED_ID(sid), .CTRL_PROG_BLOCK(4'h5), .PM1_SW(pm1_sw),
        .PM1_EFFECTIVE(pm1_eff), .FLASH_READ_EN(rd_en),
        .FLASH_POWER_EN(pwr_en), .CPU_HOLD(cpu_hold),
        .READ_STATUS_MODE(rs_mode), .PROG_CMD_ACCEPT(accept),
        .ID_FETCH_ADDR(id_addr)
    );
    frp_flash_model #(.ID_CODE(ID_CODE)) u_flash (
        .fail_req(fail_req), .vec_erased(vec_erased), .op_fail(op_fail),
        .reset_vector(rvec), .stored_id(sid)
    );
    task automatic end_of_test;
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    // Single word transfers; address held until ready, then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic bit_is(input string nm, input logic [7:0] a, input int b,
                          input logic e);
        logic [31:0] q;
        rd(a, q);
        chk1(nm, e, q[b]);
    endtask
    // Zero-then-one arming of bit 1 in either control register
    task automatic arm(input logic [7:0] a);
        wr(a, 32'h0000_0000);
        wr(a, 32'h0000_0002);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [31:0] d);
        wr(OFS_CMD, {24'h00_0000, c});
        wr(OFS_CMD_DATA, d);
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_ready;
        logic [31:0] q = '0;
        for (int i = 0; i < 800 && q[BIT_READY] !== 1'b1; i++)
            rd(OFS_CTRL_STATUS_A, q);
        chk1("ready", 1'b1, q[BIT_READY]);
    endtask
    // Watchdog: all operations together stay far below this span
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_CTRL_STATUS_A, v);
        chk("ctrl_a reset", 32'(RST_CTRL_A), v);
        rd(OFS_CTRL_B, v);
        chk("ctrl_b reset", 32'(RST_CTRL_B), v);
        rd(8'h40, v);
        chk("unmapped", 32'h0000_0000, v);
        wr(OFS_CTRL_STATUS_A, 32'h0000_0002);
        bit_is("enable direct", OFS_CTRL_STATUS_A, BIT_REWRITE_EN, 0);
        arm(OFS_CTRL_STATUS_A);
        bit_is("enable armed", OFS_CTRL_STATUS_A, BIT_REWRITE_EN, 1);
        chk("pm1 forced", 32'h0000_00A9, 32'(pm1_eff));
        // Failing program in variant zero, all blocks unlocked
        wr(OFS_CFG, 32'h0000_FFFF);
        fail_req <= 1'b1;
        cmd(CMD_PROGRAM, 32'h0003_5A5A);
        bit_is("busy", OFS_CTRL_STATUS_A, BIT_READY, 1'b0);
        chk1("array off", 1'b0, rd_en);
        wait_ready();
        chk1("status mode", 1'b1, rs_mode);
        bit_is("prog err", OFS_CTRL_STATUS_A, BIT_PROG_ERR, 1'b1);
        rd(OFS_CMD, v);
        chk("status reg", 32'h0000_0009, 32'(v[7:4]));
        fail_req <= 1'b0;
        wr(OFS_CMD, 32'(CMD_CLEAR_STATUS));
        bit_is("err clear", OFS_CTRL_STATUS_A, BIT_PROG_ERR, 1'b0);
        arm(OFS_CTRL_B);
        bit_is("variant one", OFS_CTRL_B, BIT_EW_SEL, 1'b1);
        cmd(CMD_PROGRAM, 32'h0005_5A5A);
        chk1("own block", 1'b0, cpu_hold);
        bit_is("own block rdy", OFS_CTRL_STATUS_A, BIT_READY, 1'b1);
        // Lock-status read on an unlocked, then a locked block
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CFG, k == 0 ? 32'h0000_FFFF : 32'h0000_FFF7);
            cmd(CMD_READ_LOCK, 32'h0003_00D0);
            chk1("hold", 1'b1, cpu_hold);
            wait_ready();
            bit_is("lock result", OFS_CTRL_B, BIT_LOCK_RESULT, k == 0);
            chk1("array mode", 1'b0, rs_mode);
        end
        rd(OFS_CMD, v);
        chk("status hidden", 32'h0000_0000, v);
        cmd(CMD_ERASE_ALL, 32'h0000_00D0);
        chk1("erase all", 1'b0, cpu_hold);
        cmd(CMD_BLOCK_ERASE, 32'h0004_00D0);
        chk1("erase hold", 1'b1, cpu_hold);
        susp <= 1'b1;
        repeat (3) @(posedge clk);
        chk1("suspended", 1'b0, cpu_hold);
        susp <= 1'b0;
        wait_ready();
        nmi <= 1'b1;
        repeat (2) @(posedge clk);
        nmi <= 1'b0;
        bit_is("nmi en", OFS_CTRL_STATUS_A, BIT_REWRITE_EN, 1'b0);
        bit_is("nmi sel", OFS_CTRL_B, BIT_EW_SEL, 1'b0);
        chk("pm1 back", 32'h0000_00A0, 32'(pm1_eff));
        arm(OFS_CTRL_STATUS_A);
        wdt <= 1'b1;
        repeat (2) @(posedge clk);
        wdt <= 1'b0;
        bit_is("wdt en", OFS_CTRL_STATUS_A, BIT_REWRITE_EN, 1'b0);
        // Stop, settle, restart, settle
        wr(OFS_CTRL_STATUS_A, 32'h0000_0008);
        repeat (2) @(posedge clk);
        chk1("stop read", 1'b0, rd_en);
        chk1("stop power", 1'b0, pwr_en);
        repeat (T_STAB) @(posedge clk);
        wr(OFS_CTRL_STATUS_A, 32'h0000_0000);
        repeat (T_STAB) @(posedge clk);
        chk1("restart", 1'b1, rd_en);
        lpm <= 1'b1;
        repeat (2) @(posedge clk);
        chk1("lpm off", 1'b0, pwr_en);
        lpm <= 1'b0;
        repeat (2) @(posedge clk);
        chk1("lpm on", 1'b1, pwr_en);
        par <= 1'b1;
        wr(OFS_PROG_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk1("protected", 1'b0, rd_en);
        wr(OFS_PROG_CTRL, 32'h0000_00C0);
        repeat (2) @(posedge clk);
        chk1("open", 1'b1, rd_en);
        par <= 1'b0;
        wr(OFS_ID_WORD0, ID_CODE[31:0]);
        wr(OFS_ID_WORD1, {8'h00, ID_CODE[55:32]});
        ser <= 1'b1;
        repeat (3) @(posedge clk);
        chk1("id match", 1'b1, accept);
        wr(OFS_ID_WORD0, ~ID_CODE[31:0]);
        repeat (3) @(posedge clk);
        chk1("id mismatch", 1'b0, accept);
        vec_erased <= 1'b1;
        repeat (3) @(posedge clk);
        chk1("erased vec", 1'b1, accept);
        pm1_sw <= 8'hFF;
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule
`default_nettype wire
